// *** core/sdb_defs.vh ***
`ifndef SDB_DEFS_VH
`define SDB_DEFS_VH
// ------------------------------------------------------------
// Summary of operation
// ------------------------------------------------------------
// Summary of operation
// - each byte lane has its own strobe pair, driven by the device on reads and by the controller on writes.
// - read strobe edges line up with data edges, write strobe edges sit in the middle of each data bit.
// - strobes travel only as true and complement pairs, never single ended.
// - the sixteen data lines form a lower and an upper bidirectional byte lane.
// - the array has eight banks and each core access fetches eight words for one burst.
// - one access moves eight words over four clocks, two words per link clock cycle.
// - bursts start at a chosen column and run eight transfers, or four when chopped, in sequence order.
// - a read or write takes the column from the address, auto precharge from bit 10, chop from bit 12.
// - reset is sampled through the synchroniser, holds the device while low, closes every bank and keeps the array contents.

// ------------------------------------------------------------
// commands {cs_n, ras_n, cas_n, we_n}
// ------------------------------------------------------------
`define SDB_CMD_ACT 4'h3
`define SDB_CMD_RD 4'h5
`define SDB_CMD_WR 4'h4
`define SDB_CMD_PRE 4'h2
`define SDB_CMD_MRS 4'h0
`define SDB_AP_BIT 10
`define SDB_BC_BIT 12
`define SDB_BURST_LEN 4'h8
`define SDB_CHOP_LEN 4'h4
`define SDB_BL_OTF 2'h1
`define SDB_BL_CHOP 2'h2
`define SDB_INIT_CYC 10000
`endif

// *** core/sdb_sync.v ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// two-stage synchroniser for pin inputs
// ------------------------------------------------------------
module sdb_sync #(
	parameter W = 1
) (
	input wire ref_clk_i,
	input wire resetn_i,
	input wire [W-1:0] d_i,
	output reg [W-1:0] q_o
);
	reg [W-1:0] meta_reg;
	always @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			meta_reg <= {W{1'b0}};
			q_o <= {W{1'b0}};
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule

// *** core/sdb_core.v ***
`timescale 1ns/1ps
`include "sdb_defs.vh"
module sdb_core #(
	parameter ROWS = 16,
	parameter COLS = 16,
	parameter CLK_MHZ = 20,
	parameter INIT_CYC = `SDB_INIT_CYC
) (
	// system
	input wire ref_clk_i,
	input wire resetn_i,
	// link clock and control pins
	input wire link_ck_i,
	input wire mem_reset_n_i,
	input wire cke_i,
	input wire cs_n_i,
	input wire ras_n_i,
	input wire cas_n_i,
	input wire we_n_i,
	input wire [2:0] bank_select_i,
	input wire [13:0] row_column_address_i,
	// data lanes
	input wire [7:0] lower_byte_data_i,
	output reg [7:0] lower_byte_data_o,
	output reg lower_byte_data_oe_n_o,
	input wire [7:0] upper_byte_data_i,
	output reg [7:0] upper_byte_data_o,
	output reg upper_byte_data_oe_n_o,
	// strobe pairs
	input wire [1:0] lower_lane_strobe_pair_i,
	output reg [1:0] lower_lane_strobe_pair_o,
	output reg lower_lane_strobe_pair_oe_n_o,
	input wire [1:0] upper_lane_strobe_pair_i,
	output reg [1:0] upper_lane_strobe_pair_o,
	output reg upper_lane_strobe_pair_oe_n_o,
	// status
	output reg init_done_o,
	output reg [1:0] mode_regs_seen_o
);
	localparam ST_IDLE = 2'd0;
	localparam ST_RD = 2'd1;
	localparam ST_WR = 2'd2;
	// only the low row and column bits are kept, the array is a small stand-in for the core
	localparam RB = $clog2(ROWS);
	localparam CB = $clog2(COLS);
	localparam AW = 3 + RB + CB;
	localparam integer INIT_M1 = INIT_CYC - 1;
	localparam [13:0] INIT_LAST = INIT_M1[13:0];

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	wire [43:0] s;
	sdb_sync #(.W(44)) u_sync (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.d_i({link_ck_i, mem_reset_n_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, bank_select_i,
			row_column_address_i, lower_byte_data_i, upper_byte_data_i, lower_lane_strobe_pair_i,
			upper_lane_strobe_pair_i}),
		.q_o(s)
	);
	wire ck_s = s[43];
	wire rst_n_s = s[42];
	wire cke_s = s[41];
	wire [3:0] cmd_s = s[40:37];
	wire [2:0] ba_s = s[36:34];
	wire [13:0] addr_s = s[33:20];
	// word order is {upper, lower}
	wire [15:0] dq_s = {s[11:4], s[19:12]};
	// both legs are kept so one leg moving alone to equal legs is not taken as an edge
	wire [1:0] dqsl_pair = s[3:2];
	wire [1:0] dqsu_pair = s[1:0];

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	reg ck_d_reg;
	reg [1:0] st_reg;
	reg [RB-1:0] open_reg [0:7];
	reg [7:0] act_reg;
	reg [15:0] mem [0:(1<<AW)-1];
	reg [2:0] bank_reg;
	reg [RB-1:0] row_reg;
	reg [CB-1:0] col_reg;
	reg [3:0] beat_reg;
	reg [3:0] len_reg;
	reg ap_reg;
	reg [1:0] dqsl_d_reg;
	reg [1:0] dqsu_d_reg;
	reg [13:0] init_cnt_reg;
	reg [1:0] mr0_bl_reg;
	integer i;

	wire ck_edge = ck_s != ck_d_reg;
	wire ck_rise = ck_s & ~ck_d_reg;
	wire cmd_ok = ck_rise & cke_s & init_done_o & (st_reg == ST_IDLE);
	// differential edge: the pair must have changed and its legs must differ, a lone leg is ignored
	wire wl_edge = (dqsl_pair != dqsl_d_reg) & (dqsl_pair[1] != dqsl_pair[0]);
	wire wu_edge = (dqsu_pair != dqsu_d_reg) & (dqsu_pair[1] != dqsu_pair[0]);

	function [AW-1:0] addr_of;
		input [2:0] b;
		input [RB-1:0] r;
		input [CB-1:0] c;
		begin
			addr_of = {b, r, c};
		end
	endfunction

	// burst sequence: column wraps inside its group of eight
	function [CB-1:0] seq_col;
		input [CB-1:0] c0;
		input [3:0] n;
		begin
			seq_col = {c0[CB-1:3], c0[2:0] + n[2:0]};
		end
	endfunction

	wire [CB-1:0] cur_col = seq_col(col_reg, beat_reg);
	wire [AW-1:0] cur_addr = addr_of(bank_reg, row_reg, cur_col);

	always @(posedge ref_clk_i) begin
		if (!resetn_i || !rst_n_s) begin
			// pin reset is sampled, so it acts within a few clocks of going low
			ck_d_reg <= 1'b0;
			st_reg <= ST_IDLE;
			act_reg <= 8'h00;
			bank_reg <= 3'h0;
			row_reg <= {RB{1'b0}};
			col_reg <= {CB{1'b0}};
			beat_reg <= 4'h0;
			len_reg <= `SDB_BURST_LEN;
			ap_reg <= 1'b0;
			dqsl_d_reg <= 2'b01;
			dqsu_d_reg <= 2'b01;
			init_cnt_reg <= 14'h0000;
			init_done_o <= 1'b0;
			mr0_bl_reg <= 2'h0;
			mode_regs_seen_o <= 2'h0;
			lower_byte_data_o <= 8'h00;
			upper_byte_data_o <= 8'h00;
			lower_byte_data_oe_n_o <= 1'b1;
			upper_byte_data_oe_n_o <= 1'b1;
			lower_lane_strobe_pair_o <= 2'b01;
			upper_lane_strobe_pair_o <= 2'b01;
			lower_lane_strobe_pair_oe_n_o <= 1'b1;
			upper_lane_strobe_pair_oe_n_o <= 1'b1;
			for (i = 0; i < 8; i = i + 1) begin
				open_reg[i] <= {RB{1'b0}};
			end
		end else begin
			ck_d_reg <= ck_s;
			dqsl_d_reg <= dqsl_pair;
			dqsu_d_reg <= dqsu_pair;
			// internal init runs on our clock, not the link clock
			if (!init_done_o) begin
				if (init_cnt_reg == INIT_LAST)
					init_done_o <= 1'b1;
				else
					init_cnt_reg <= init_cnt_reg + 14'h0001;
			end
			case (st_reg)
				ST_IDLE: begin
					if (cmd_ok) begin
						case (cmd_s)
							`SDB_CMD_MRS: begin
								mode_regs_seen_o <= ba_s[1:0];
								if (ba_s[1:0] == 2'h0)
									mr0_bl_reg <= addr_s[1:0];
							end
							`SDB_CMD_ACT: begin
								act_reg[ba_s] <= 1'b1;
								open_reg[ba_s] <= addr_s[RB-1:0];
							end
							`SDB_CMD_PRE: begin
								if (addr_s[`SDB_AP_BIT])
									act_reg <= 8'h00;
								else
									act_reg[ba_s] <= 1'b0;
							end
							`SDB_CMD_RD, `SDB_CMD_WR: begin
								if (act_reg[ba_s]) begin
									bank_reg <= ba_s;
									row_reg <= open_reg[ba_s];
									col_reg <= addr_s[CB-1:0];
									ap_reg <= addr_s[`SDB_AP_BIT];
									if (mr0_bl_reg == `SDB_BL_CHOP || (mr0_bl_reg == `SDB_BL_OTF
										&& !addr_s[`SDB_BC_BIT]))
										len_reg <= `SDB_CHOP_LEN;
									else
										len_reg <= `SDB_BURST_LEN;
									beat_reg <= 4'h0;
									st_reg <= (cmd_s == `SDB_CMD_RD) ? ST_RD : ST_WR;
								end
							end
							default: begin
							end
						endcase
					end
				end
				ST_RD: begin
					// one word per link clock edge, strobe toggles with data
					if (ck_edge) begin
						if (beat_reg == len_reg) begin
							lower_byte_data_oe_n_o <= 1'b1;
							upper_byte_data_oe_n_o <= 1'b1;
							lower_lane_strobe_pair_oe_n_o <= 1'b1;
							upper_lane_strobe_pair_oe_n_o <= 1'b1;
							if (ap_reg)
								act_reg[bank_reg] <= 1'b0;
							st_reg <= ST_IDLE;
						end else begin
							{upper_byte_data_o, lower_byte_data_o} <= mem[cur_addr];
							lower_byte_data_oe_n_o <= 1'b0;
							upper_byte_data_oe_n_o <= 1'b0;
							// toggling from idle gives the first word an edge too, and an even count ends at idle
							lower_lane_strobe_pair_o <= ~lower_lane_strobe_pair_o;
							upper_lane_strobe_pair_o <= ~upper_lane_strobe_pair_o;
							lower_lane_strobe_pair_oe_n_o <= 1'b0;
							upper_lane_strobe_pair_oe_n_o <= 1'b0;
							beat_reg <= beat_reg + 4'h1;
						end
					end
				end
				ST_WR: begin
					// controller strobes sit mid-bit, so data is stable on its edge
					if (wl_edge || wu_edge) begin
						mem[cur_addr] <= dq_s;
						if (beat_reg == len_reg - 4'h1) begin
							if (ap_reg)
								act_reg[bank_reg] <= 1'b0;
							st_reg <= ST_IDLE;
						end
						beat_reg <= beat_reg + 4'h1;
					end
				end
				default: st_reg <= ST_IDLE;
			endcase
		end
	end
endmodule

// *** test/sdb_core_sva.sv ***
`timescale 1ns/1ps
module sdb_core_sva(
	input wire ref_clk_i,
	input wire resetn_i,
	input wire mem_reset_n_i,
	input wire [7:0] lower_byte_data_o,
	input wire [7:0] upper_byte_data_o,
	input wire lower_byte_data_oe_n_o,
	input wire upper_byte_data_oe_n_o,
	input wire [1:0] lower_lane_strobe_pair_o,
	input wire [1:0] upper_lane_strobe_pair_o,
	input wire lower_lane_strobe_pair_oe_n_o,
	input wire upper_lane_strobe_pair_oe_n_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	chk_lower_strobe_diff: assert property (^lower_lane_strobe_pair_o)
		else $error("lower strobe not differential");
	chk_upper_strobe_diff: assert property (^upper_lane_strobe_pair_o)
		else $error("upper strobe not differential");
	chk_lanes_together: assert property (lower_byte_data_oe_n_o == upper_byte_data_oe_n_o)
		else $error("lanes drive apart");
	chk_strobe_with_data: assert property (lower_byte_data_oe_n_o == lower_lane_strobe_pair_oe_n_o)
		else $error("strobe drive apart from data");
	chk_edge_aligned: assert property (!lower_byte_data_oe_n_o && !$past(lower_byte_data_oe_n_o)
		&& $changed(lower_byte_data_o) |-> $changed(lower_lane_strobe_pair_o)) else $error("data moved without strobe");
	chk_upper_strobe_drive: assert property (upper_byte_data_oe_n_o == upper_lane_strobe_pair_oe_n_o)
		else $error("upper strobe drive apart from data");
	chk_upper_edge_aligned: assert property (!upper_byte_data_oe_n_o && !$past(upper_byte_data_oe_n_o)
		&& $changed(upper_byte_data_o) |-> $changed(upper_lane_strobe_pair_o)) else $error("upper data moved alone");
	chk_burst_span: assert property ($fell(lower_byte_data_oe_n_o)
		|-> !lower_byte_data_oe_n_o [*8] ##[1:48] lower_byte_data_oe_n_o) else $error("burst length off");
	chk_reset_idle: assert property (disable iff (1'b0) !resetn_i
		|=> lower_byte_data_oe_n_o && lower_lane_strobe_pair_o == 2'b01) else $error("not idle in reset");
	chk_pin_reset_idle: assert property (!mem_reset_n_i [*3]
		|=> lower_byte_data_oe_n_o && lower_byte_data_o == 8'h00) else $error("not idle in pin reset");
endmodule

// *** test/sdb_ctrl_model.sv ***
`timescale 1ns/1ps
module sdb_ctrl_model(
	output logic ck_o,
	output logic [3:0] cmd_o,
	output logic [2:0] ba_o,
	output logic [13:0] ad_o,
	output logic [15:0] wd_o,
	output logic [1:0] dqs_o,
	output logic en_n_o
);
	logic [15:0] w = 16'h0000;
	initial ck_o = 1'b0;
	initial cmd_o = 4'hf;
	initial ba_o = 3'h0;
	initial ad_o = 14'h0000;
	initial dqs_o = 2'b01;
	initial en_n_o = 1'b1;
	always #200 ck_o = ~ck_o;
	// released lanes show the inverse so stale data never matches
	assign wd_o = en_n_o ? ~w : w;
	task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
		@(negedge ck_o);
		cmd_o <= c;
		ba_o <= b;
		ad_o <= a;
		@(negedge ck_o);
		cmd_o <= 4'hf;
	endtask
	// strobe edge sits mid-bit, pair stays complementary
	task automatic wr(input logic [15:0] d0, input int n);
		en_n_o <= 1'b0;
		for (int i = 0; i < n; i++) begin
			w <= d0 + 16'(i);
			#100 dqs_o <= ~dqs_o;
			#100;
		end
		en_n_o <= 1'b1;
	endtask
endmodule

// *** test/sdram_burst_access_init_tb_top.sv ***
`timescale 1ns/1ps
`include "sdb_defs.vh"
module sdram_burst_access_init_tb_top;
	logic ref_clk_i = 0;
	logic resetn_i = 0;
	logic mrst_n = 0;
	logic cke = 0;
	logic ck, en_n, ol, ou, sol, sou, done;
	logic [3:0] cmd;
	logic [2:0] ba;
	logic [13:0] ad;
	logic [15:0] wd;
	wire [15:0] rd;
	logic [1:0] dqs, sl, su, ms;
	logic [1:0] sl_d = 2'b01;
	logic [15:0] q[$];
	int err_total = 0;
	int total_checks = 0;
	always #25 ref_clk_i = ~ref_clk_i;
	sdb_ctrl_model u_ctrl(.ck_o(ck), .cmd_o(cmd), .ba_o(ba), .ad_o(ad), .wd_o(wd), .dqs_o(dqs), .en_n_o(en_n));
	sdb_core #(.INIT_CYC(20)) DUT(.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link_ck_i(ck), .mem_reset_n_i(mrst_n),
		.cke_i(cke), .cs_n_i(cmd[3]), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .bank_select_i(ba),
		.row_column_address_i(ad), .lower_byte_data_i(ol ? wd[7:0] : rd[7:0]), .lower_byte_data_o(rd[7:0]),
		.lower_byte_data_oe_n_o(ol), .upper_byte_data_i(ou ? wd[15:8] : rd[15:8]), .upper_byte_data_o(rd[15:8]),
		.upper_byte_data_oe_n_o(ou), .lower_lane_strobe_pair_i(sol ? dqs : sl), .lower_lane_strobe_pair_o(sl),
		.lower_lane_strobe_pair_oe_n_o(sol), .upper_lane_strobe_pair_i(sou ? dqs : su), .upper_lane_strobe_pair_o(su),
		.upper_lane_strobe_pair_oe_n_o(sou), .init_done_o(done), .mode_regs_seen_o(ms));
	always @(posedge ref_clk_i) begin
		sl_d <= sl;
		if (ol === 1'b0 && sl !== sl_d)
			q.push_back(rd);
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd_burst(input logic [2:0] b, input logic [13:0] a, input int n);
		q.delete();
		u_ctrl.cmd(`SDB_CMD_RD, b, a);
		repeat (60) @(posedge ref_clk_i);
		chk(16'(q.size()), 16'(n));
		foreach (q[i]) chk(q[i], 16'h3c40 + 16'((a + i) & 7));
	endtask
	task automatic t_init;
		repeat (4) @(posedge ref_clk_i);
		resetn_i <= 1;
		mrst_n <= 1;
		repeat (12) @(posedge ref_clk_i);
		chk(16'(done), 16'h0000);
		repeat (14) @(posedge ref_clk_i);
		chk(16'(done), 16'h0001);
		cke <= 1;
	endtask
	task automatic t_mrs;
		logic [2:0] seq [4] = '{3'h2, 3'h3, 3'h1, 3'h0};
		for (int i = 0; i < 4; i++) begin
			u_ctrl.cmd(`SDB_CMD_MRS, seq[i], i == 3 ? 14'h0101 : 14'h0000);
			repeat (8) @(posedge ref_clk_i);
			chk(16'(ms), 16'(seq[i][1:0]));
		end
	endtask
	task automatic t_rw;
		u_ctrl.cmd(`SDB_CMD_ACT, 3'h3, 14'h0005);
		u_ctrl.cmd(`SDB_CMD_WR, 3'h3, 14'h1000);
		u_ctrl.wr(16'h3c40, 8);
		repeat (20) @(posedge ref_clk_i);
		rd_burst(3'h3, 14'h1002, 8);
		rd_burst(3'h3, 14'h0004, 4);
		rd_burst(3'h1, 14'h1000, 0);
		rd_burst(3'h3, 14'h1400, 8);
		rd_burst(3'h3, 14'h1000, 0);
	endtask
	task automatic t_modes;
		u_ctrl.cmd(`SDB_CMD_ACT, 3'h3, 14'h0005);
		u_ctrl.cmd(`SDB_CMD_PRE, 3'h0, 14'h0000);
		rd_burst(3'h3, 14'h1002, 8);
		u_ctrl.cmd(`SDB_CMD_PRE, 3'h0, 14'h0400);
		rd_burst(3'h3, 14'h1000, 0);
		u_ctrl.cmd(`SDB_CMD_ACT, 3'h3, 14'h0005);
		u_ctrl.cmd(`SDB_CMD_MRS, 3'h0, 14'h0002);
		rd_burst(3'h3, 14'h1002, 4);
	endtask
	task automatic t_reset;
		u_ctrl.cmd(`SDB_CMD_RD, 3'h3, 14'h1000);
		repeat (10) @(posedge ref_clk_i);
		chk(16'(ol), 16'h0000);
		mrst_n <= 0;
		cke <= 0;
		repeat (4) @(posedge ref_clk_i);
		chk(16'(ol), 16'h0001);
		chk(16'(done), 16'h0000);
		mrst_n <= 1;
		repeat (30) @(posedge ref_clk_i);
		chk(16'(done), 16'h0001);
		cke <= 1;
		rd_burst(3'h3, 14'h1000, 0);
	endtask
	task automatic complete_run;
		if (err_total == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		t_init;
		t_mrs;
		t_rw;
		t_modes;
		t_reset;
		complete_run;
	end
	initial begin
		#400000;
		err_total++;
		complete_run;
	end
endmodule
bind sdb_core sdb_core_sva u_sva(.*);
